// >>> include/rcfc_defines.svh
/*
 * Register indices, field positions, reset values and widths of the reference
 * frequency-source configuration bank.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef RCFC_DEFINES_SVH
`define RCFC_DEFINES_SVH

// printed offsets are indices: byte address is index times four
`define RCFC_IDX_MODE_SEL 8'h65
`define RCFC_IDX_RATE_LO 8'h67
`define RCFC_IDX_RATE_HI 8'h68
`define RCFC_IDX_CYC_LO 8'h69
`define RCFC_IDX_CYC_HI 8'h6a
`define RCFC_IDX_WIN_LO_L 8'h6b
`define RCFC_IDX_WIN_LO_H 8'h6c
`define RCFC_IDX_WIN_HI_L 8'h6d
`define RCFC_IDX_WIN_HI_H 8'h6e
`define RCFC_IDX_STATUS 8'h7f

`define RCFC_RST_BYTE 8'h00
`define RCFC_RST_WORD 32'h0000_0000

`define RCFC_SEL_W 2
`define RCFC_RATE_W 14
`define RCFC_RATE_HI_W 6
`define RCFC_WIN_W 16
`define RCFC_RATE_UNIT_KHZ 8

// status layout: profile A active per input, then reserved code seen per input
`define RCFC_STAT_USE_A_LSB 0
`define RCFC_STAT_RSVD_LSB 3

`define RCFC_IDX_LSB 2
`define RCFC_IDX_MSB 9
`define RCFC_HTRANS_NONSEQ 2'h2
`define RCFC_HRESP_OKAY 1'h0

`endif

// >>> include/rcfc_pkg.sv
/*
 * Types of the reference frequency-source configuration bank.
 * Assumes rcfc_defines.svh on the include path.
 */
`include "rcfc_defines.svh"

package rcfc_pkg;

   typedef enum logic [1:0] {
      RCFC_SRC_AUTO = 2'h0,
      RCFC_SRC_PROFILE_A = 2'h1,
      RCFC_SRC_PROFILE_B = 2'h2,
      RCFC_SRC_RESERVED = 2'h3
   } rcfc_src_e_t;

   typedef struct packed {
      logic en;
      logic [7:0] idx;
      logic [7:0] data;
   } rcfc_wr_t;

   typedef struct packed {
      logic [`RCFC_RATE_W-1:0] rate;
      logic [7:0] cyc_lo;
      logic [7:0] cyc_hi;
      logic [`RCFC_WIN_W-1:0] win_lo;
      logic [`RCFC_WIN_W-1:0] win_hi;
   } rcfc_prof_a_t;

   typedef struct packed {
      rcfc_src_e_t src;
      logic use_a;
      logic rsvd;
      rcfc_prof_a_t prof;
   } rcfc_mon_cfg_t;

endpackage

// >>> rtl/rcfc_ahb_slave.sv
/*
 * AHB-Lite slave front end: catches address phases, presents the write in its
 * data phase and the read index in its address phase.
 * Assumes one clock, zero wait states and word-aligned single transfers.
 */
`include "rcfc_defines.svh"
module rcfc_ahb_slave
   import rcfc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output rcfc_wr_t wr,
   output logic rd_en,
   output logic [7:0] rd_idx
);

   logic addr_ok;
   logic take;
   logic wr_pend_q;
   logic [7:0] wr_idx_q;

   // bits above the index window make the address unmapped
   assign addr_ok = (haddr[31:`RCFC_IDX_MSB+1] == '0);
   assign take = hsel && hready && (htrans == `RCFC_HTRANS_NONSEQ);
   assign rd_en = take && !hwrite && addr_ok;
   assign rd_idx = haddr[`RCFC_IDX_MSB:`RCFC_IDX_LSB];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= `RCFC_RST_BYTE;
      end else begin
         wr_pend_q <= take && hwrite && addr_ok;
         wr_idx_q <= haddr[`RCFC_IDX_MSB:`RCFC_IDX_LSB];
      end
   end

   assign wr.en = wr_pend_q;
   assign wr.idx = wr_idx_q;
   assign wr.data = hwdata[7:0];

endmodule

// >>> rtl/rcfc_ref_select.sv
/*
 * Per-input decode of the frequency-source selectors and routing of the
 * profile A settings to the reference monitors. Purely combinational.
 * Assumes the selector byte and profile settings are the next values of the bank registers.
 */
`include "rcfc_defines.svh"
module rcfc_ref_select
   import rcfc_pkg::*;
#(
   parameter int NUM_INPUTS = 3
)
(
   input wire logic [7:0] mode_sel,
   input wire rcfc_prof_a_t prof_a,
   output rcfc_mon_cfg_t [NUM_INPUTS-1:0] mon_cfg
);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_in
         logic [`RCFC_SEL_W-1:0] code;
         logic is_a;
         assign code = mode_sel[gi*`RCFC_SEL_W +: `RCFC_SEL_W];
         assign is_a = (code == RCFC_SRC_PROFILE_A);
         assign mon_cfg[gi].src = rcfc_src_e_t'(code);
         assign mon_cfg[gi].use_a = is_a;
         assign mon_cfg[gi].rsvd = (code == RCFC_SRC_RESERVED);
         // other sources see zeros so a stale profile cannot leak in
         assign mon_cfg[gi].prof = is_a ? prof_a : '0;
      end
   endgenerate

endmodule

// >>> rtl/rcfc_top.sv
/*
 * Reference frequency-source configuration bank: source selectors for three
 * reference inputs and the custom profile A frequency and monitor limits,
 * reached over AHB-Lite and fed to the reference monitoring logic.
 * Assumes a single hclk domain, the only slave on its bus, word transfers.
 */
// The AHB-Lite slave port was decided locally.
// Summary of operation
// - two-bit source select per input: auto, A, B
// - profile A rate: 14 bits, 8 kHz units
// - rate bits 13:8 from second byte
// - hold 8-bit single-cycle lower bound
// - hold 8-bit single-cycle upper bound
// - window lower bound low byte
// - window lower bound high byte
// - window upper bound low byte
// - window upper bound high byte
`include "rcfc_defines.svh"
module rcfc_top
   import rcfc_pkg::*;
#(
   parameter int NUM_INPUTS = 3
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output rcfc_mon_cfg_t [NUM_INPUTS-1:0] mon_cfg
);

   rcfc_wr_t wr;
   logic rd_en;
   logic [7:0] rd_idx;

   // bus front end: zero wait states, a write lands one cycle after its address
   rcfc_ahb_slave u_bus (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .wr(wr),
      .rd_en(rd_en),
      .rd_idx(rd_idx)
   );

   // write strobes per register
   // status and unmapped indices match no strobe, so writes there are dropped
   logic we_mode;
   logic we_rate_lo;
   logic we_rate_hi;
   logic we_cyc_lo;
   logic we_cyc_hi;
   logic we_win_lo_l;
   logic we_win_lo_h;
   logic we_win_hi_l;
   logic we_win_hi_h;

   assign we_mode = wr.en && (wr.idx == `RCFC_IDX_MODE_SEL);
   assign we_rate_lo = wr.en && (wr.idx == `RCFC_IDX_RATE_LO);
   assign we_rate_hi = wr.en && (wr.idx == `RCFC_IDX_RATE_HI);
   assign we_cyc_lo = wr.en && (wr.idx == `RCFC_IDX_CYC_LO);
   assign we_cyc_hi = wr.en && (wr.idx == `RCFC_IDX_CYC_HI);
   assign we_win_lo_l = wr.en && (wr.idx == `RCFC_IDX_WIN_LO_L);
   assign we_win_lo_h = wr.en && (wr.idx == `RCFC_IDX_WIN_LO_H);
   assign we_win_hi_l = wr.en && (wr.idx == `RCFC_IDX_WIN_HI_L);
   assign we_win_hi_h = wr.en && (wr.idx == `RCFC_IDX_WIN_HI_H);

   // register state and next values
   logic [7:0] mode_q;
   logic [7:0] mode_d;
   logic [7:0] rate_lo_q;
   logic [7:0] rate_lo_d;
   logic [`RCFC_RATE_HI_W-1:0] rate_hi_q;
   logic [`RCFC_RATE_HI_W-1:0] rate_hi_d;
   logic [7:0] cyc_lo_q;
   logic [7:0] cyc_lo_d;
   logic [7:0] cyc_hi_q;
   logic [7:0] cyc_hi_d;
   logic [7:0] win_lo_l_q;
   logic [7:0] win_lo_l_d;
   logic [7:0] win_lo_h_q;
   logic [7:0] win_lo_h_d;
   logic [7:0] win_hi_l_q;
   logic [7:0] win_hi_l_d;
   logic [7:0] win_hi_h_q;
   logic [7:0] win_hi_h_d;

   // selector bits 7:6 are stored as written; software keeps them at zero
   assign mode_d = we_mode ? wr.data : mode_q;
   assign rate_lo_d = we_rate_lo ? wr.data : rate_lo_q;
   // top two bits of the second rate byte are not stored and stay zero
   assign rate_hi_d = we_rate_hi ? wr.data[`RCFC_RATE_HI_W-1:0] : rate_hi_q;
   assign cyc_lo_d = we_cyc_lo ? wr.data : cyc_lo_q;
   assign cyc_hi_d = we_cyc_hi ? wr.data : cyc_hi_q;
   assign win_lo_l_d = we_win_lo_l ? wr.data : win_lo_l_q;
   assign win_lo_h_d = we_win_lo_h ? wr.data : win_lo_h_q;
   assign win_hi_l_d = we_win_hi_l ? wr.data : win_hi_l_q;
   assign win_hi_h_d = we_win_hi_h ? wr.data : win_hi_h_q;

   // selector byte: three two-bit codes, bits 7:6 kept as written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= `RCFC_RST_BYTE;
      end else begin
         mode_q <= mode_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_lo_q <= `RCFC_RST_BYTE;
      end else begin
         rate_lo_q <= rate_lo_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_hi_q <= '0;
      end else begin
         rate_hi_q <= rate_hi_d;
      end
   end

   // single-cycle monitor limits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_lo_q <= `RCFC_RST_BYTE;
      end else begin
         cyc_lo_q <= cyc_lo_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_hi_q <= `RCFC_RST_BYTE;
      end else begin
         cyc_hi_q <= cyc_hi_d;
      end
   end

   // window limits: two bytes each, written independently, no atomic update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_lo_l_q <= `RCFC_RST_BYTE;
      end else begin
         win_lo_l_q <= win_lo_l_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_lo_h_q <= `RCFC_RST_BYTE;
      end else begin
         win_lo_h_q <= win_lo_h_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_hi_l_q <= `RCFC_RST_BYTE;
      end else begin
         win_hi_l_q <= win_hi_l_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         win_hi_h_q <= `RCFC_RST_BYTE;
      end else begin
         win_hi_h_q <= win_hi_h_d;
      end
   end

   // profile A assembled from the next values so outputs track writes at once
   rcfc_prof_a_t prof_a_d;
   assign prof_a_d.rate = {rate_hi_d, rate_lo_d};
   assign prof_a_d.cyc_lo = cyc_lo_d;
   assign prof_a_d.cyc_hi = cyc_hi_d;
   assign prof_a_d.win_lo = {win_lo_h_d, win_lo_l_d};
   assign prof_a_d.win_hi = {win_hi_h_d, win_hi_l_d};

   rcfc_mon_cfg_t [NUM_INPUTS-1:0] mon_cfg_d;

   // decode on next values so the monitor copy lands with the write
   rcfc_ref_select #(
      .NUM_INPUTS(NUM_INPUTS)
   ) u_sel (
      .mode_sel(mode_d),
      .prof_a(prof_a_d),
      .mon_cfg(mon_cfg_d)
   );

   // registered so every monitor input comes straight from a flop
   rcfc_mon_cfg_t [NUM_INPUTS-1:0] mon_cfg_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mon_cfg_q <= '0;
      end else begin
         mon_cfg_q <= mon_cfg_d;
      end
   end

   assign mon_cfg = mon_cfg_q;

   // status shows what the monitors are actually being fed
   logic [7:0] status_d;
   logic [NUM_INPUTS-1:0] use_a_vec;
   logic [NUM_INPUTS-1:0] rsvd_vec;

   // one bit per input keeps the status layout tied to NUM_INPUTS
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_stat
         assign use_a_vec[gi] = mon_cfg_d[gi].use_a;
         assign rsvd_vec[gi] = mon_cfg_d[gi].rsvd;
      end
   endgenerate

   always_comb begin
      status_d = `RCFC_RST_BYTE;
      status_d[`RCFC_STAT_USE_A_LSB +: NUM_INPUTS] = use_a_vec;
      status_d[`RCFC_STAT_RSVD_LSB +: NUM_INPUTS] = rsvd_vec;
   end

   // read mux on next values: a read right behind a write sees the new data
   logic [7:0] rd_byte;

   always_comb begin
      case (rd_idx)
         `RCFC_IDX_MODE_SEL: rd_byte = mode_d;
         `RCFC_IDX_RATE_LO: rd_byte = rate_lo_d;
         `RCFC_IDX_RATE_HI: rd_byte = {2'h0, rate_hi_d};
         `RCFC_IDX_CYC_LO: rd_byte = cyc_lo_d;
         `RCFC_IDX_CYC_HI: rd_byte = cyc_hi_d;
         `RCFC_IDX_WIN_LO_L: rd_byte = win_lo_l_d;
         `RCFC_IDX_WIN_LO_H: rd_byte = win_lo_h_d;
         `RCFC_IDX_WIN_HI_L: rd_byte = win_hi_l_d;
         `RCFC_IDX_WIN_HI_H: rd_byte = win_hi_h_d;
         `RCFC_IDX_STATUS: rd_byte = status_d;
         default: rd_byte = `RCFC_RST_BYTE;
      endcase
   end

   // read data lands one cycle after its address phase, in the data phase
   logic [31:0] hrdata_q;
   logic [31:0] hrdata_d;

   // unmapped reads return zero; hsize is not checked, all transfers are words
   assign hrdata_d = rd_en ? {24'h00_0000, rd_byte} : `RCFC_RST_WORD;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= `RCFC_RST_WORD;
      end else begin
         hrdata_q <= hrdata_d;
      end
   end

   logic hreadyout_q;
   logic hresp_q;

   // zero wait states: every transfer finishes in its first data cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
      end else begin
         hreadyout_q <= 1'b1;
      end
   end

   // no access is ever refused, so the response stays okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_q <= `RCFC_HRESP_OKAY;
      end else begin
         hresp_q <= `RCFC_HRESP_OKAY;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;

endmodule

// >>> sim/rcfc_top_checker.sv
/*
 * Port-level assertions for the reference source configuration bank.
 * Assumes one hclk domain, hready fed from hreadyout, bound to rcfc_top.
 */
`include "rcfc_defines.svh"
module rcfc_top_checker
   import rcfc_pkg::*;
#(
   parameter int NUM_INPUTS = 3
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire rcfc_mon_cfg_t [NUM_INPUTS-1:0] mon_cfg
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // address phase of a mapped word, upper address bits clear
   wire logic take = hsel && hready && htrans == 2'h2 && haddr[31:10] == 22'h0;
   wire logic [7:0] ix = haddr[9:2];
   wire logic wr_mode = take && hwrite && ix == `RCFC_IDX_MODE_SEL;
   property p_rdy; hreadyout && !hresp; endproperty
   a_rdy: assert property (p_rdy) else $error("ready or response wrong");
   property p_hi0; hrdata[31:8] == 24'h00_0000; endproperty
   a_hi0: assert property (p_hi0) else $error("read data upper bits set");
   property p_src; wr_mode |-> ##2 mon_cfg[0].src == $past(hwdata[1:0]); endproperty
   a_src: assert property (p_src) else $error("input0 selector not taken");
   property p_only; !$stable(mon_cfg[0].src) |-> $past(wr_mode, 2); endproperty
   a_only: assert property (p_only) else $error("selector changed without write");
   property p_use; mon_cfg[0].use_a == (mon_cfg[0].src == RCFC_SRC_PROFILE_A); endproperty
   a_use: assert property (p_use) else $error("use_a decode wrong");
   property p_rsv; mon_cfg[2].rsvd == (mon_cfg[2].src == RCFC_SRC_RESERVED); endproperty
   a_rsv: assert property (p_rsv) else $error("reserved decode wrong");
   property p_zero; !mon_cfg[2].use_a |-> mon_cfg[2].prof == '0; endproperty
   a_zero: assert property (p_zero) else $error("profile leaks to input");
   property p_same; mon_cfg[0].use_a && mon_cfg[1].use_a |-> mon_cfg[0].prof == mon_cfg[1].prof; endproperty
   a_same: assert property (p_same) else $error("inputs see different profile");
   property p_rhi; take && !hwrite && ix == `RCFC_IDX_RATE_HI |=> hrdata[7:6] == 2'h0; endproperty
   a_rhi: assert property (p_rhi) else $error("rate high top bits stored");
   property p_rlo;
      take && hwrite && ix == `RCFC_IDX_RATE_LO ##0 mon_cfg[1].use_a
         |-> ##2 mon_cfg[1].prof.rate[7:0] == $past(hwdata[7:0]);
   endproperty
   a_rlo: assert property (p_rlo) else $error("rate low byte not routed");
   property p_whh;
      take && hwrite && ix == `RCFC_IDX_WIN_HI_H ##0 mon_cfg[1].use_a
         |-> ##2 mon_cfg[1].prof.win_hi[15:8] == $past(hwdata[7:0]);
   endproperty
   a_whh: assert property (p_whh) else $error("window upper high byte not routed");
   c_mode: cover property (wr_mode);
   c_use: cover property (mon_cfg[1].use_a);
   c_rsv: cover property (mon_cfg[0].rsvd);
endmodule

bind rcfc_top rcfc_top_checker #(.NUM_INPUTS(NUM_INPUTS)) u_chk (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .haddr(haddr),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hwdata(hwdata),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .mon_cfg(mon_cfg)
);

// >>> sim/testbench.sv
/*
 * Self-checking bench: AHB-Lite master tasks, readback and monitor checks.
 * Assumes rcfc_top as the only slave, hready taken from hreadyout.
 */
`include "rcfc_defines.svh"
module testbench
   import rcfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic [31:0] hrdata;
   wire logic hreadyout;
   wire logic hresp;
   rcfc_mon_cfg_t [2:0] mon_cfg;
   int n_fail = 0;
   int total_checks = 0;
   logic [7:0] ix [9] = '{`RCFC_IDX_MODE_SEL, `RCFC_IDX_RATE_LO, `RCFC_IDX_RATE_HI, `RCFC_IDX_CYC_LO,
      `RCFC_IDX_CYC_HI, `RCFC_IDX_WIN_LO_L, `RCFC_IDX_WIN_LO_H, `RCFC_IDX_WIN_HI_L, `RCFC_IDX_WIN_HI_H};
   // selector keeps bits 7:6 clear; rate high 0xff probes the dropped bits
   logic [7:0] v [9] = '{8'h24, 8'h5a, 8'hff, 8'h12, 8'he7, 8'h34, 8'hc8, 8'h9b, 8'h6d};
   rcfc_prof_a_t ep;
   logic [31:0] r;
   logic [31:0] st;
   logic [7:0] s;
   logic [1:0] c;
   always #5 hclk = ~hclk;
   rcfc_top uut (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hreadyout),
      .hwdata(hwdata),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .mon_cfg(mon_cfg)
   );
   // entered just after a rising edge; upper data bits carry junk on purpose
   task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [31:0] q);
      hsel <= 1'h1;
      haddr <= {22'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'ha5_a5a5, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_mon(input int i, input rcfc_mon_cfg_t e);
      total_checks++;
      if (mon_cfg[i] !== e) begin
         n_fail++;
         $display("[ERR] mon_cfg %0d expected %h seen %h", i, e, mon_cfg[i]);
      end
   endtask
   task automatic rd_all(input logic z);
      for (int k = 0; k < 9; k++) begin
         xfer(1'h0, ix[k], 8'h00, r);
         chk($sformatf("reg %h", ix[k]), z ? 32'h0 : {24'h0, k == 2 ? v[k] & 8'h3f : v[k]}, r);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      chk_mon(0, '0);
      rd_all(1'h1);
      for (int k = 0; k < 9; k++) begin
         xfer(1'h1, ix[k], v[k], r);
      end
      ep = {v[2][5:0], v[1], v[3], v[4], v[6], v[5], v[8], v[7]};
      rd_all(1'h0);
      xfer(1'h1, 8'h66, 8'hff, r);
      xfer(1'h0, 8'h66, 8'h00, r);
      chk("unmapped", 32'h0, r);
      chk("hresp", 32'h0, {31'h0, hresp});
      // walk every code through every input
      for (int k = 0; k < 4; k++) begin
         s = {2'h0, 2'(k + 2), 2'(k + 1), 2'(k)};
         st = 32'h0;
         xfer(1'h1, `RCFC_IDX_MODE_SEL, s, r);
         xfer(1'h0, `RCFC_IDX_STATUS, 8'h00, r);
         for (int i = 0; i < 3; i++) begin
            c = s[2*i+:2];
            st[i] = c == 2'h1;
            st[3+i] = c == 2'h3;
            chk_mon(i, {c, c == 2'h1, c == 2'h3, c == 2'h1 ? ep : 62'h0});
         end
         chk("status", st, r);
      end
      hresetn <= 1'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      chk_mon(1, '0);
      rd_all(1'h1);
      finish_test();
   end
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
endmodule
